//--- src/pcs_defines.svh
// constants for the privilege check and context sync unit
// assumes a 32-bit big-endian instruction word, bit 31 is the msb
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_OPC_SYS       6'h1f
`define PCS_OPC_SC        6'h11
`define PCS_OPC_RFX       6'h13
`define PCS_XO_RFI        10'h032
`define PCS_XO_RFCI       10'h033
`define PCS_XO_ISYNC      10'h096
`define PCS_XO_MFMSR      10'h053
`define PCS_XO_MTMSR      10'h092
`define PCS_XO_MFSPR      10'h153
`define PCS_XO_MTSPR      10'h1d3
`define PCS_XO_MFDCR      10'h143
`define PCS_XO_MTDCR      10'h1c3
`define PCS_XO_WRTEE      10'h083
`define PCS_XO_WRTEEI     10'h0a3
`define PCS_XO_DCBI       10'h1d6
`define PCS_XO_DCCCI      10'h1c6
`define PCS_XO_DCREAD     10'h1e6
`define PCS_XO_ICCCI      10'h3c6
`define PCS_XO_ICREAD     10'h3e6
`define PCS_XO_TLBIA      10'h172
`define PCS_XO_TLBRE      10'h3b2
`define PCS_XO_TLBSX      10'h392
`define PCS_XO_TLBSYNC    10'h236
`define PCS_XO_TLBWE      10'h3d2
`define PCS_XO_SYNC       10'h256
`define PCS_XO_EIEIO      10'h356
`define PCS_SPR_XER       10'h001
`define PCS_SPR_LR        10'h008
`define PCS_SPR_CTR       10'h009
`define PCS_SPR_UGR0      10'h100
`define PCS_SPR_GR4_RD    10'h104
`define PCS_SPR_GR7_RD    10'h107
`define PCS_PROG_OFFSET   16'h0700
`define PCS_MSR_PR_BIT    14
`define PCS_MSR_RESET     32'h0000_0000
`endif

//--- src/pcs_pkg.sv
// types for the privilege check and context sync unit
// assumes nothing beyond the defines header
package pcs_pkg;
	typedef enum logic [1:0] {
		PCS_IDLE,
		PCS_DRAIN,
		PCS_REFETCH
	} pcs_state_t;
endpackage : pcs_pkg

//--- src/pcs_core.sv
// privilege check, problem-state control and context synchronisation
// assumes decode presents one instruction per valid cycle, same clock
//
// Overview of operation
// RL1 - problem-state bit one means user mode
// RL2 - reset clears problem-state bit
// RL3 - interrupt saves state register, clears problem-state
// RL4 - user privileged op suppressed, program vector taken
// RL5 - privileged violation sets syndrome flag
// RL6 - cache, dcr, msr, return, tlb ops privileged
// RL7 - special registers privileged except listed few
// RL8 - time base read unprivileged, writes privileged
// RL9 - special register number halves are swapped
// RL10 - encoded field msb one means privileged
// RL11 - device control moves always privileged
// RL12 - interrupts, isync, returns, syscall synchronise context; code does not sync an interrupt taken with INT_NOSYNC_IN set
// RL13 - context sync does not order memory
// RL14 - both barriers drain memory accesses identically
// RL15 - device control contents outside context
// RL16 - barriers keep prefetch running, no purge
// RL17 - isync discards prefetched instructions, refetch
// RL18 - instruction cache state is context
// RL19 - software isyncs after entering user mode
// RL20 - software barriers and isyncs around region change
// RL21 - software isyncs after debug compare enable
// RL22 - software orders self-modifying code sequence
// RL23 - check at decode before any state change
`timescale 1ns/100ps
`include "pcs_defines.svh"
module pcs_core
	import pcs_pkg::*;
(
	input  wire logic        CLK_IN,           // core clock 200 MHz
	input  wire logic        RST_IN,           // sync reset, high
	input  wire logic        INSN_VALID_IN,    // decode word valid
	input  wire logic [31:0] INSN_IN,          // instruction word
	input  wire logic        INT_TAKE_IN,      // interrupt taken pulse
	input  wire logic        INT_CRIT_IN,      // interrupt is critical
	input  wire logic        INT_NOSYNC_IN,    // unrecoverable i-mcheck
	input  wire logic        MSR_WR_IN,        // msr move executes
	input  wire logic [31:0] MSR_WDATA_IN,     // value to msr
	input  wire logic        RET_IN,           // interrupt return
	input  wire logic        RET_CRIT_IN,      // return is critical
	input  wire logic [31:0] SAVED_NC_IN,      // restore from nc save
	input  wire logic [31:0] SAVED_CR_IN,      // restore from crit save
	input  wire logic [15:0] VEC_PREFIX_IN,    // vector prefix upper
	input  wire logic        MEM_IDLE_IN,      // no memory op pending
	input  wire logic        ESR_CLR_IN,       // software clears syndrome
	output logic [31:0] MSR_OUT,          // machine state register
	output logic        USER_MODE_OUT,    // problem state active
	output logic [31:0] NC_SAVE_OUT,      // noncritical saved state
	output logic [31:0] CR_SAVE_OUT,      // critical saved state
	output logic        PRIV_FAULT_OUT,   // suppress and trap pulse
	output logic [31:0] FAULT_VEC_OUT,    // program vector address
	output logic        ESR_PRIV_OUT,     // privilege violation flag
	output logic        CTX_SYNC_OUT,     // context sync event pulse
	output logic        FLUSH_OUT,        // discard prefetch pulse
	output logic        MEM_HOLD_OUT,     // hold later memory ops
	output logic        ISSUE_STALL_OUT   // stall decode
);

	////////////////////////////////////////////////////////////////
	// decode
	logic [5:0]  opc;
	logic [9:0]  xo;
	logic [9:0]  spr_field;
	logic [9:0]  spr_num;
	logic        is_sys;
	logic        is_mfspr;
	logic        is_mtspr;
	logic        spr_open;
	logic        spr_priv;
	logic        dcr_op;
	logic        base_priv;
	logic        priv_op;
	logic        is_isync;
	logic        is_rfx;
	logic        is_sc;
	logic        is_barrier;
	logic        violate;
	logic        user_mode;

	assign opc       = INSN_IN[31:26];
	assign xo        = INSN_IN[10:1];
	assign spr_field = INSN_IN[20:11];
	// halves are stored swapped in the word [RL9]
	assign spr_num   = {spr_field[4:0], spr_field[9:5]}; // [RL9]
	assign is_sys    = (opc == `PCS_OPC_SYS);
	assign is_mfspr  = is_sys && (xo == `PCS_XO_MFSPR);
	assign is_mtspr  = is_sys && (xo == `PCS_XO_MTSPR);
	// time base reads use a separate opcode, never trapped [RL8]
	assign spr_open  = (spr_num == `PCS_SPR_XER) ||
		(spr_num == `PCS_SPR_LR) || (spr_num == `PCS_SPR_CTR) ||
		(is_mfspr && spr_num >= `PCS_SPR_GR4_RD &&
		spr_num <= `PCS_SPR_GR7_RD) || (spr_num == `PCS_SPR_UGR0); // [RL7]
	// encoded msb set marks privileged, even for the open list [RL10]
	assign spr_priv  = (is_mfspr || is_mtspr) &&
		(spr_field[9] || !spr_open); // [RL7] [RL8] [RL10]
	assign dcr_op    = is_sys && (xo == `PCS_XO_MFDCR ||
		xo == `PCS_XO_MTDCR); // [RL11]
	assign is_rfx    = (opc == `PCS_OPC_RFX) &&
		(xo == `PCS_XO_RFI || xo == `PCS_XO_RFCI);
	assign is_isync  = (opc == `PCS_OPC_RFX) && (xo == `PCS_XO_ISYNC);
	assign is_sc     = (opc == `PCS_OPC_SC);
	assign is_barrier = is_sys &&
		(xo == `PCS_XO_SYNC || xo == `PCS_XO_EIEIO); // [RL14]
	assign base_priv = is_rfx || (is_sys && (xo == `PCS_XO_MFMSR ||
		xo == `PCS_XO_MTMSR || xo == `PCS_XO_WRTEE ||
		xo == `PCS_XO_WRTEEI || xo == `PCS_XO_DCBI ||
		xo == `PCS_XO_DCCCI || xo == `PCS_XO_DCREAD ||
		xo == `PCS_XO_ICCCI || xo == `PCS_XO_ICREAD ||
		xo == `PCS_XO_TLBIA || xo == `PCS_XO_TLBRE ||
		xo == `PCS_XO_TLBSX || xo == `PCS_XO_TLBSYNC ||
		xo == `PCS_XO_TLBWE)); // [RL6]
	assign priv_op   = base_priv || dcr_op || spr_priv; // [RL6] [RL11]
	assign user_mode = MSR_OUT[`PCS_MSR_PR_BIT]; // [RL1]
	// judged in decode, before anything can retire [RL23]
	assign violate   = INSN_VALID_IN && user_mode && priv_op; // [RL4]

	assign USER_MODE_OUT  = user_mode; // [RL1]
	assign PRIV_FAULT_OUT = violate; // [RL4] [RL23]
	assign FAULT_VEC_OUT  = {VEC_PREFIX_IN, `PCS_PROG_OFFSET}; // [RL4]

	////////////////////////////////////////////////////////////////
	// machine state and saves
	logic [31:0] msr_next;
	logic [31:0] msr_int;
	logic [31:0] nc_save_next;
	logic [31:0] cr_save_next;
	logic        esr_next;
	logic        take_int;

	// a violation is itself a program interrupt
	assign take_int = INT_TAKE_IN || violate;
	assign msr_int  = MSR_OUT & ~(32'h1 << `PCS_MSR_PR_BIT); // [RL3]

	always_comb begin
		msr_next     = MSR_OUT;
		nc_save_next = NC_SAVE_OUT;
		cr_save_next = CR_SAVE_OUT;
		if (take_int) begin
			msr_next = msr_int; // [RL3]
			if (INT_CRIT_IN && !violate) begin
				cr_save_next = MSR_OUT; // [RL3]
			end else begin
				nc_save_next = MSR_OUT; // [RL3]
			end
		end else if (RET_IN) begin
			msr_next = RET_CRIT_IN ? SAVED_CR_IN : SAVED_NC_IN;
		end else if (MSR_WR_IN) begin
			msr_next = MSR_WDATA_IN;
		end
	end

	// set wins over a clear in the same cycle
	assign esr_next = violate ? 1'b1 :
		(ESR_CLR_IN ? 1'b0 : ESR_PRIV_OUT); // [RL5]

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			MSR_OUT      <= `PCS_MSR_RESET; // [RL2]
			NC_SAVE_OUT  <= 32'h0000_0000;
			CR_SAVE_OUT  <= 32'h0000_0000;
			ESR_PRIV_OUT <= 1'b0;
		end else begin
			MSR_OUT      <= msr_next;
			NC_SAVE_OUT  <= nc_save_next;
			CR_SAVE_OUT  <= cr_save_next;
			ESR_PRIV_OUT <= esr_next; // [RL5]
		end
	end

	////////////////////////////////////////////////////////////////
	// context sync and barrier sequencing
	pcs_state_t state_reg;
	pcs_state_t state_next;
	logic       sync_insn;
	logic       sync_event;
	logic       barrier_go;

	// device control writes and memory order are not context here
	assign sync_insn  = INSN_VALID_IN && !violate &&
		(is_isync || is_rfx || is_sc); // [RL12] [RL13] [RL15]
	assign sync_event = (INT_TAKE_IN && !INT_NOSYNC_IN) || violate ||
		sync_insn; // [RL12] [RL18]
	assign barrier_go = INSN_VALID_IN && !violate && is_barrier;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PCS_IDLE: begin
				if (barrier_go && !MEM_IDLE_IN) begin
					state_next = PCS_DRAIN; // [RL14]
				end else if (sync_event) begin
					state_next = PCS_REFETCH; // [RL17]
				end
			end
			PCS_DRAIN: begin
				if (MEM_IDLE_IN) begin
					state_next = PCS_IDLE; // [RL14]
				end
			end
			PCS_REFETCH: begin
				state_next = PCS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_reg <= PCS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign CTX_SYNC_OUT    = (state_reg == PCS_IDLE) && sync_event;
	// barriers hold memory only, prefetch keeps going [RL16]
	assign FLUSH_OUT       = CTX_SYNC_OUT; // [RL17]
	assign MEM_HOLD_OUT    = (state_reg == PCS_DRAIN) ||
		(barrier_go && !MEM_IDLE_IN); // [RL14] [RL16]
	assign ISSUE_STALL_OUT = (state_reg == PCS_REFETCH);

	////////////////////////////////////////////////////////////////
	// checks
	property p_reset_priv;
		@(posedge CLK_IN) RST_IN |=> !MSR_OUT[`PCS_MSR_PR_BIT];
	endproperty
	a_reset_priv: assert property (p_reset_priv) // [RL2]
		else $error("problem state not cleared by reset");

	property p_int_clears_pr;
		@(posedge CLK_IN) disable iff (RST_IN)
		take_int |=> !USER_MODE_OUT;
	endproperty
	a_int_clears_pr: assert property (p_int_clears_pr) // [RL3]
		else $error("interrupt left user mode set");

	property p_int_saves;
		@(posedge CLK_IN) disable iff (RST_IN)
		(take_int && !(INT_CRIT_IN && !violate)) |=>
		NC_SAVE_OUT == $past(MSR_OUT);
	endproperty
	a_int_saves: assert property (p_int_saves) // [RL3]
		else $error("noncritical save lost state");

	property p_fault_vec;
		@(posedge CLK_IN) disable iff (RST_IN)
		PRIV_FAULT_OUT |-> FAULT_VEC_OUT[15:0] == 16'h0700 &&
		FAULT_VEC_OUT[31:16] == VEC_PREFIX_IN;
	endproperty
	a_fault_vec: assert property (p_fault_vec) // [RL4]
		else $error("wrong program vector");

	property p_esr_set;
		@(posedge CLK_IN) disable iff (RST_IN)
		PRIV_FAULT_OUT |=> ESR_PRIV_OUT;
	endproperty
	a_esr_set: assert property (p_esr_set) // [RL5]
		else $error("syndrome flag not set");

	property p_dcr_user;
		@(posedge CLK_IN) disable iff (RST_IN)
		(INSN_VALID_IN && USER_MODE_OUT && dcr_op) |-> PRIV_FAULT_OUT;
	endproperty
	a_dcr_user: assert property (p_dcr_user) // [RL11]
		else $error("user dcr move not trapped");

	property p_lr_open;
		@(posedge CLK_IN) disable iff (RST_IN)
		(INSN_VALID_IN && is_mfspr && spr_field == 10'h100) |->
		!PRIV_FAULT_OUT;
	endproperty
	a_lr_open: assert property (p_lr_open) // [RL7] [RL9]
		else $error("link register read trapped");

	property p_super_free;
		@(posedge CLK_IN) disable iff (RST_IN)
		!USER_MODE_OUT |-> !PRIV_FAULT_OUT;
	endproperty
	a_super_free: assert property (p_super_free) // [RL1]
		else $error("fault raised in privileged mode");

	property p_isync_flush;
		@(posedge CLK_IN) disable iff (RST_IN)
		(state_reg == PCS_IDLE && INSN_VALID_IN && is_isync &&
		!USER_MODE_OUT) |-> FLUSH_OUT ##1 ISSUE_STALL_OUT;
	endproperty
	a_isync_flush: assert property (p_isync_flush) // [RL17]
		else $error("isync did not flush");

	property p_barrier_noflush;
		@(posedge CLK_IN) disable iff (RST_IN)
		(barrier_go && !INT_TAKE_IN) |->
		(!FLUSH_OUT && (MEM_HOLD_OUT || MEM_IDLE_IN)) ##1
		!ISSUE_STALL_OUT;
	endproperty
	a_barrier_noflush: assert property (p_barrier_noflush) // [RL16]
		else $error("barrier flushed or released memory");

	property p_drain_hold;
		@(posedge CLK_IN) disable iff (RST_IN)
		(state_reg == PCS_DRAIN && !MEM_IDLE_IN) |=>
		(state_reg == PCS_DRAIN) && MEM_HOLD_OUT;
	endproperty
	a_drain_hold: assert property (p_drain_hold) // [RL14]
		else $error("barrier released memory early");

endmodule : pcs_core

//--- tb/tb_top.sv
// self-checking bench for the privilege check and context sync unit
// assumes pcs_core with its defines header, one 200 MHz clock
`timescale 1ns/100ps
`include "pcs_defines.svh"
module tb_top;
	logic        clk_in = 1'b0, rst_in = 1'b1, iv = 1'b0, it = 1'b0;
	logic        ic = 1'b0, nsy = 1'b0, mw = 1'b0, ret = 1'b0;
	logic        retc = 1'b0, mi = 1'b1, ec = 1'b0;
	logic [31:0] insn = 32'h0, mwd = 32'h0, snc = 32'h0, scr = 32'h0;
	logic [15:0] vp = 16'hc3a5;
	logic [31:0] machine_state_register, ncs, crs, fv;
	logic        um, pf, ep, cs, fl, mh, st;
	int          error_cnt = 0;
	int          cmp_count = 0;
	localparam logic [31:0] UMSR = 32'h0000_c030;
	localparam logic [9:0]  PX [16] = '{`PCS_XO_DCBI, `PCS_XO_DCCCI,
		`PCS_XO_DCREAD, `PCS_XO_ICCCI, `PCS_XO_ICREAD, `PCS_XO_MFDCR,
		`PCS_XO_MTDCR, `PCS_XO_MFMSR, `PCS_XO_MTMSR, `PCS_XO_TLBIA,
		`PCS_XO_TLBRE, `PCS_XO_TLBSX, `PCS_XO_TLBSYNC, `PCS_XO_TLBWE,
		`PCS_XO_WRTEE, `PCS_XO_WRTEEI};
	// xo, special register number, fault expected in user mode
	localparam logic [20:0] SX [16] = '{
		{`PCS_XO_MFSPR, `PCS_SPR_LR, 1'b0},
		{`PCS_XO_MTSPR, `PCS_SPR_LR, 1'b0},
		{`PCS_XO_MFSPR, `PCS_SPR_CTR, 1'b0},
		{`PCS_XO_MTSPR, `PCS_SPR_CTR, 1'b0},
		{`PCS_XO_MFSPR, `PCS_SPR_XER, 1'b0},
		{`PCS_XO_MTSPR, `PCS_SPR_XER, 1'b0},
		{`PCS_XO_MFSPR, `PCS_SPR_UGR0, 1'b0},
		{`PCS_XO_MTSPR, `PCS_SPR_UGR0, 1'b0},
		{`PCS_XO_MFSPR, `PCS_SPR_GR4_RD, 1'b0},
		{`PCS_XO_MFSPR, `PCS_SPR_GR7_RD, 1'b0},
		{`PCS_XO_MTSPR, `PCS_SPR_GR4_RD, 1'b1},
		{`PCS_XO_MTSPR, `PCS_SPR_GR7_RD, 1'b1},
		{`PCS_XO_MFSPR, 10'h01a, 1'b1},
		{`PCS_XO_MTSPR, 10'h01a, 1'b1},
		{`PCS_XO_MFSPR, 10'h108, 1'b1},
		{`PCS_XO_MTSPR, 10'h11c, 1'b1}};
	localparam logic [31:0] ISYNC = {`PCS_OPC_RFX, 15'h0, `PCS_XO_ISYNC,
		1'b0};
	// debug control number, arbitrary privileged value
	localparam logic [9:0]  DBG_SPR = 10'h3f0;

	always #2.5 clk_in = ~clk_in;

	pcs_core i_dut (.CLK_IN(clk_in), .RST_IN(rst_in), .INSN_VALID_IN(iv),
		.INSN_IN(insn), .INT_TAKE_IN(it), .INT_CRIT_IN(ic),
		.INT_NOSYNC_IN(nsy), .MSR_WR_IN(mw), .MSR_WDATA_IN(mwd),
		.RET_IN(ret), .RET_CRIT_IN(retc), .SAVED_NC_IN(snc),
		.SAVED_CR_IN(scr), .VEC_PREFIX_IN(vp), .MEM_IDLE_IN(mi),
		.ESR_CLR_IN(ec), .MSR_OUT(machine_state_register), .USER_MODE_OUT(um),
		.NC_SAVE_OUT(ncs), .CR_SAVE_OUT(crs), .PRIV_FAULT_OUT(pf),
		.FAULT_VEC_OUT(fv), .ESR_PRIV_OUT(ep), .CTX_SYNC_OUT(cs),
		.FLUSH_OUT(fl), .MEM_HOLD_OUT(mh), .ISSUE_STALL_OUT(st));

	////////////////////////////////////////////////////////////////////////
	task conclude;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task tick;
		@(posedge clk_in);
		#1;
	endtask : tick

	function automatic logic [31:0] xf(input logic [9:0] xo,
		input logic [9:0] n);
		return {`PCS_OPC_SYS, 5'h00, n[4:0], n[9:5], xo, 1'b0};
	endfunction : xf

	////////////////////////////////////////////////////////////////////////
	task t_rst;
		rst_in = 1'b1;
		repeat (4) tick;
		rst_in = 1'b0;
		chk(machine_state_register, `PCS_MSR_RESET);
		chk(um, 1'b0);
		chk(ncs, 32'h0);
		chk(crs, 32'h0);
		chk(ep, 1'b0);
		chk(st, 1'b0);
	endtask : t_rst

	task automatic issue(input logic [31:0] x, input logic e);
		iv = 1'b1;
		insn = x;
		#1;
		chk(cs, e);
		tick;
		iv = 1'b0;
		chk(st, e);
		tick;
	endtask : issue

	task go_user;
		mw = 1'b1;
		mwd = UMSR;
		tick;
		mw = 1'b0;
		chk(um, 1'b1);
		chk(machine_state_register, UMSR);
		issue(ISYNC, 1'b1);
	endtask : go_user

	task automatic try(input logic [31:0] x, input logic e);
		logic [31:0] old;
		old = machine_state_register;
		iv = 1'b1;
		insn = x;
		#1;
		chk(pf, e);
		chk(fl, e);
		if (e) chk(fv, {vp, `PCS_PROG_OFFSET});
		tick;
		iv = 1'b0;
		chk(um, e ? 1'b0 : old[`PCS_MSR_PR_BIT]);
		chk(ep, e);
		chk(st, e);
		if (e) begin
			chk(ncs, old);
			tick;
			ec = 1'b1;
			tick;
			ec = 1'b0;
			chk(ep, 1'b0);
			go_user;
		end
	endtask : try

	task automatic t_sync;
		logic [31:0] sl [4];
		sl = '{ISYNC, {`PCS_OPC_SC, 26'h0000002},
			{`PCS_OPC_RFX, 15'h0, `PCS_XO_RFI, 1'b0},
			{`PCS_OPC_RFX, 15'h0, `PCS_XO_RFCI, 1'b0}};
		foreach (sl[i]) begin
			iv = 1'b1;
			insn = sl[i];
			#1;
			chk(cs, 1'b1);
			chk(fl, 1'b1);
			tick;
			iv = 1'b0;
			chk(st, 1'b1);
			tick;
			chk(st, 1'b0);
		end
	endtask : t_sync

	task automatic t_bar;
		logic [9:0] bl [2];
		bl = '{`PCS_XO_SYNC, `PCS_XO_EIEIO};
		foreach (bl[i]) begin
			mi = 1'b0;
			iv = 1'b1;
			insn = xf(bl[i], 10'h0);
			#1;
			chk(mh, 1'b1);
			chk(fl, 1'b0);
			chk(cs, 1'b0);
			tick;
			iv = 1'b0;
			repeat (2) begin
				chk(mh, 1'b1);
				chk(st, 1'b0);
				tick;
			end
			mi = 1'b1;
			tick;
			chk(mh, 1'b0);
		end
	endtask : t_bar

	task automatic t_int(input logic c, input logic n);
		logic [31:0] old;
		old = machine_state_register;
		it = 1'b1;
		ic = c;
		nsy = n;
		#1;
		chk(cs, !n);
		tick;
		it = 1'b0;
		ic = 1'b0;
		nsy = 1'b0;
		chk(um, 1'b0);
		chk(c ? crs : ncs, old);
		tick;
		go_user;
	endtask : t_int

	task t_ret(input logic c);
		ret = 1'b1;
		retc = c;
		snc = 32'h0000_4001;
		scr = 32'h0000_0102;
		tick;
		ret = 1'b0;
		chk(machine_state_register, c ? scr : snc);
		chk(um, !c);
	endtask : t_ret

	task t_soft;
		// a store is still outstanding when the barrier decodes
		mi = 1'b0;
		issue(xf(`PCS_XO_SYNC, 10'h0), 1'b0);
		chk(mh, 1'b1);
		mi = 1'b1;
		tick;
		chk(mh, 1'b0);
		issue(xf(`PCS_XO_MTDCR, 10'h0), 1'b0);
		issue(ISYNC, 1'b1);
		issue(xf(`PCS_XO_MTSPR, DBG_SPR), 1'b0);
		issue(ISYNC, 1'b1);
		mi = 1'b0;
		issue(xf(`PCS_XO_SYNC, 10'h0), 1'b0);
		mi = 1'b1;
		tick;
		issue(xf(`PCS_XO_ICCCI, 10'h0), 1'b0);
		issue(ISYNC, 1'b1);
	endtask : t_soft

	task t_esr;
		go_user;
		ec = 1'b1;
		iv = 1'b1;
		insn = xf(`PCS_XO_MTMSR, 10'h0);
		tick;
		iv = 1'b0;
		ec = 1'b0;
		chk(ep, 1'b1);
		tick;
		ec = 1'b1;
		tick;
		ec = 1'b0;
		chk(ep, 1'b0);
	endtask : t_esr

	////////////////////////////////////////////////////////////////////////
	initial begin
		t_rst;
		foreach (PX[i]) try(xf(PX[i], 10'h008), 1'b0);
		t_sync;
		t_bar;
		t_soft;
		go_user;
		foreach (PX[i]) try(xf(PX[i], 10'h008), 1'b1);
		try({`PCS_OPC_RFX, 15'h0, `PCS_XO_RFI, 1'b0}, 1'b1);
		try({`PCS_OPC_RFX, 15'h0, `PCS_XO_RFCI, 1'b0}, 1'b1);
		foreach (SX[i]) begin
			try(xf(SX[i][20:11], SX[i][10:1]), SX[i][0]);
		end
		try(xf(10'h173, 10'h10c), 1'b0);
		for (int c = 0; c < 2; c++) t_int(c[0], 1'b0);
		t_int(1'b0, 1'b1);
		t_ret(1'b0);
		t_ret(1'b1);
		t_esr;
		go_user;
		t_rst;
		conclude;
	end

	initial begin
		#100000;
		error_cnt++;
		conclude;
	end
endmodule : tb_top
